//--- src/aec_control.sv
`timescale 1ns/1ps
// Overview of operation
// - EQ search picks smallest EQ with hits >= mid*(128-eq threshold)/128; reset 4.
// - Swing search picks largest swing with hits >= mid*swing threshold/128; reset 6.
// - Threshold fields apply only in mode 2'b10; otherwise reset values used.
// - Full adaptation runs when mode is 1, 2 or 3 and enable set.
// - Fast adaptation runs when mode is 0 and enable set.
// - Fast adaptation only reachable under I2C configuration, never under straps.
// - Fast mode classifies channel short or long and applies matching preset.
// - Short channel uses per-lane short registers; host programs them 1-2 dB above loss.
// - Long channel uses per-lane long registers; host programs them 4-5 dB above loss.
// - Under I2C, full adaptation is enabled by default without any write.
// - Under straps, adaptation follows the active-low disable strap.
// - Config from straps or I2C; I2C sets each receiver independently.
// - Both address straps floating give target address 0x12.
// - Target address derives from the two address strap levels.
// - Fixed mode applies one setting from straps or short registers.
// - Mid-eye capture holds the programmed capture EQ in modes 10 and 11.
// - Pos/neg results merge to max, or to min when merge bit is 1 in mode 2'b10.
// - Per-lane status shows adapted EQ, also the fast-mode EQ.
module aec_control #(
  parameter int HC_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic config_mode_strap_in,
  input wire logic [1:0] host_eq_addr_strap_hi_in,
  input wire logic [1:0] host_eq_addr_strap_lo_in,
  input wire logic [3:0] conn_eq_straps_in,
  input wire logic adaptation_disable_strap_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output wire logic sda_out,
  output wire logic sda_oe_n_out,
  input wire logic adapt_start_in,
  input wire logic hit_valid_in,
  input wire logic [HC_W-1:0] hit_count_in,
  input wire logic channel_valid_in,
  input wire logic [1:0] channel_long_in,
  output wire logic probe_req_out,
  output wire logic probe_lane_out,
  output wire logic probe_neg_out,
  output wire logic [aec_pkg::EQ_W-1:0] probe_swing_out,
  output wire logic adapt_busy_out,
  output wire logic [aec_pkg::EQ_W-1:0] conn_lane1_eq_out,
  output wire logic [aec_pkg::EQ_W-1:0] conn_lane2_eq_out,
  output wire logic [aec_pkg::EQ_W-1:0] host_lane1_eq_out,
  output wire logic [aec_pkg::EQ_W-1:0] host_lane2_eq_out
);
  import aec_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] pair_idx(input logic [1:0] hi, input logic [1:0] lo);
    logic [3:0] h;
    logic [3:0] l;
    h = {2'h0, hi[1] ? 2'h2 : hi};
    l = {2'h0, lo[1] ? 2'h2 : lo};
    return (h << 1) + h + l;
  endfunction

  function automatic logic [HC_W-1:0] scale_hits(input logic [HC_W-1:0] hc,
                                                 input logic [7:0] k);
    logic [HC_W+7:0] p;
    p = {8'h00, hc} * {{HC_W{1'b0}}, k};
    return p[HC_W+HIT_SHIFT-1:HIT_SHIFT];
  endfunction

  // ****************************************
  // Synchronisers and strap capture
  // ****************************************
  logic [9:0] strap_s1, strap_s2, strap, next_strap;
  logic [1:0] i2c_s1, i2c_s2, i2c_d;
  logic [1:0] cap_cnt, next_cap_cnt;
  logic cfg_ready, i2c_mode, adapt_en;
  logic [6:0] dev_addr;

  always_comb begin
    next_cap_cnt = cap_cnt;
    next_strap = strap;
    if (cap_cnt != STRAP_WAIT) begin
      next_cap_cnt = cap_cnt + 2'h1;
      next_strap = strap_s2;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_s1 <= '0;
      strap_s2 <= '0;
      strap <= '0;
      cap_cnt <= '0;
      i2c_s1 <= 2'h3;
      i2c_s2 <= 2'h3;
      i2c_d <= 2'h3;
    end else begin
      strap_s1 <= {config_mode_strap_in, host_eq_addr_strap_hi_in, host_eq_addr_strap_lo_in,
                   conn_eq_straps_in, adaptation_disable_strap_n_in};
      strap_s2 <= strap_s1;
      strap <= next_strap;
      cap_cnt <= next_cap_cnt;
      i2c_s1 <= {scl_in, sda_in};
      i2c_s2 <= i2c_s1;
      i2c_d <= i2c_s2;
    end
  end

  assign cfg_ready = (cap_cnt == STRAP_WAIT);
  assign i2c_mode = strap[9];
  assign dev_addr = ADDR_BASE + {3'h0, pair_idx(strap[8:7], strap[6:5])};

  // ****************************************
  // Register file and I2C target
  // ****************************************
  aec_i2c_t ist, next_ist;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] rx, next_rx, tx, next_tx, ptr, next_ptr, rd_val;
  logic rw, next_rw, nack, next_nack, drv, next_drv;
  logic [7:0] ctrl, next_ctrl, thr, next_thr, midc, next_midc, host, next_host;
  logic [7:0] short1, next_short1, short2, next_short2, long1, next_long1, long2, next_long2;
  logic [3:0] stat1, stat2;
  logic scl_rise, scl_fall, i2c_start, i2c_stop;

  assign scl_rise = i2c_s2[1] & ~i2c_d[1];
  assign scl_fall = ~i2c_s2[1] & i2c_d[1];
  assign i2c_start = i2c_s2[1] & i2c_d[1] & i2c_d[0] & ~i2c_s2[0];
  assign i2c_stop = i2c_s2[1] & i2c_d[1] & ~i2c_d[0] & i2c_s2[0];

  always_comb begin
    case (ptr)
      REG_LANE1_ADAPTED: rd_val = {4'h0, stat1};
      REG_LANE2_ADAPTED: rd_val = {4'h0, stat2};
      REG_MIDCAPTURE: rd_val = midc;
      REG_HIT_THRESHOLDS: rd_val = thr;
      REG_ADAPT_CTRL: rd_val = ctrl;
      REG_LANE1_SHORT: rd_val = short1;
      REG_LANE2_SHORT: rd_val = short2;
      REG_LANE1_LONG: rd_val = long1;
      REG_LANE2_LONG: rd_val = long2;
      REG_HOST_EQ: rd_val = host;
      default: rd_val = 8'h00;
    endcase
  end

  always_comb begin
    next_ist = ist;
    next_bitcnt = bitcnt;
    next_rx = rx;
    next_tx = tx;
    next_ptr = ptr;
    next_rw = rw;
    next_nack = nack;
    next_drv = drv;
    next_ctrl = ctrl;
    next_thr = thr;
    next_midc = midc;
    next_host = host;
    next_short1 = short1;
    next_short2 = short2;
    next_long1 = long1;
    next_long2 = long2;
    if (i2c_start) begin
      next_ist = I_ADDR;
      next_bitcnt = 4'h0;
      next_drv = 1'b0;
    end else if (i2c_stop) begin
      next_ist = I_IDLE;
      next_drv = 1'b0;
    end else if (ist != I_IDLE && scl_rise) begin
      if (bitcnt < BIT_ACK) next_rx = {rx[6:0], i2c_s2[0]};
      else next_nack = i2c_s2[0];
      next_bitcnt = bitcnt + 4'h1;
    end else if (ist != I_IDLE && scl_fall) begin
      if (bitcnt == BIT_ACK) begin
        next_drv = 1'b0;
        case (ist)
          I_ADDR: begin
            if (rx[7:1] == dev_addr && i2c_mode) begin
              next_drv = 1'b1;
              next_rw = rx[0];
            end else begin
              next_ist = I_IDLE;
            end
          end
          I_PTR: begin
            next_drv = 1'b1;
            next_ptr = rx;
          end
          I_WDATA: begin
            next_drv = 1'b1;
            next_ptr = ptr + 8'h01;
            case (ptr)
              REG_MIDCAPTURE: next_midc = {3'h0, rx[MERGE_BIT:0]};
              REG_HIT_THRESHOLDS:
                next_thr = {rx[7:EQ_THR_LSB], 1'b0, rx[SWING_THR_MSB:0]};
              REG_ADAPT_CTRL: next_ctrl = {5'h00, rx[ENABLE_BIT:0]};
              REG_LANE1_SHORT: next_short1 = {4'h0, rx[3:0]};
              REG_LANE2_SHORT: next_short2 = {4'h0, rx[3:0]};
              REG_LANE1_LONG: next_long1 = {4'h0, rx[3:0]};
              REG_LANE2_LONG: next_long2 = {4'h0, rx[3:0]};
              REG_HOST_EQ: next_host = rx;
              default: next_ptr = ptr + 8'h01;
            endcase
          end
          default: next_drv = 1'b0;
        endcase
      end else if (bitcnt == BIT_END) begin
        next_bitcnt = 4'h0;
        next_drv = 1'b0;
        if (ist == I_ADDR) next_ist = rw ? I_RDATA : I_PTR;
        else if (ist == I_PTR) next_ist = I_WDATA;
        else if (ist == I_RDATA && nack) next_ist = I_IDLE;
        if ((ist == I_ADDR && rw) || (ist == I_RDATA && !nack)) begin
          next_tx = rd_val;
          next_drv = ~rd_val[7];
          next_ptr = ptr + 8'h01;
        end
      end else if (ist == I_RDATA) begin
        next_drv = ~tx[6];
        next_tx = {tx[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ist <= I_IDLE;
      bitcnt <= 4'h0;
      rx <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      drv <= 1'b0;
      ctrl <= ADAPT_CTRL_RST;
      thr <= HIT_THRESHOLDS_RST;
      midc <= MIDCAPTURE_RST;
      host <= HOST_EQ_RST;
      short1 <= CONN_EQ_RST;
      short2 <= CONN_EQ_RST;
      long1 <= CONN_EQ_RST;
      long2 <= CONN_EQ_RST;
    end else begin
      ist <= next_ist;
      bitcnt <= next_bitcnt;
      rx <= next_rx;
      tx <= next_tx;
      ptr <= next_ptr;
      rw <= next_rw;
      nack <= next_nack;
      drv <= next_drv;
      ctrl <= next_ctrl;
      thr <= next_thr;
      midc <= next_midc;
      host <= next_host;
      short1 <= next_short1;
      short2 <= next_short2;
      long1 <= next_long1;
      long2 <= next_long2;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n_out = ~drv;

  // ****************************************
  // Adaptation engine
  // ****************************************
  aec_mode_t mode;
  aec_eng_t eng, next_eng;
  logic lane, next_lane, done, next_done;
  logic [3:0] swing, next_swing, eq, next_eq, eqp, next_eqp, next_stat1, next_stat2;
  logic [3:0] mid_eq, eq_thr_ff, sw_thr;
  logic [2:0] eq_thr;
  logic [HC_W-1:0] mid_hits, next_mid_hits, eq_target, sw_target;
  logic merge_min;

  assign mode = i2c_mode ? aec_mode_t'(ctrl[1:0]) : MODE_FULL;
  assign adapt_en = cfg_ready && (i2c_mode ? ctrl[ENABLE_BIT] : strap[0]);
  assign eq_thr = (mode == MODE_TUNED) ? thr[7:EQ_THR_LSB] :
                  HIT_THRESHOLDS_RST[7:EQ_THR_LSB];
  assign sw_thr = (mode == MODE_TUNED) ? thr[SWING_THR_MSB:0] :
                  HIT_THRESHOLDS_RST[SWING_THR_MSB:0];
  assign eq_thr_ff = {1'b0, eq_thr};
  assign eq_target = scale_hits(mid_hits, HIT_SCALE - {4'h0, eq_thr_ff});
  assign sw_target = scale_hits(mid_hits, {4'h0, sw_thr});
  assign mid_eq = mode[1] ? midc[3:0] : MIDCAPTURE_RST[3:0];
  assign merge_min = (mode == MODE_TUNED) && midc[MERGE_BIT];

  always_comb begin
    logic [3:0] res;
    res = (merge_min ? (eqp < eq) : (eqp > eq)) ? eqp : eq;
    next_eng = eng;
    next_lane = lane;
    next_done = done;
    next_swing = swing;
    next_eq = eq;
    next_eqp = eqp;
    next_mid_hits = mid_hits;
    next_stat1 = stat1;
    next_stat2 = stat2;
    case (eng)
      ENG_IDLE: begin
        if (adapt_start_in && adapt_en) begin
          next_lane = 1'b0;
          next_done = 1'b0;
          next_eng = (mode == MODE_FAST) ? ENG_FAST : ENG_MID;
        end
      end
      ENG_MID: begin
        if (hit_valid_in) begin
          next_mid_hits = hit_count_in;
          next_swing = SETTING_MAX;
          next_eng = ENG_VOD;
        end
      end
      ENG_VOD: begin
        if (hit_valid_in) begin
          if (hit_count_in >= sw_target || swing == 4'h0) begin
            next_eq = 4'h0;
            next_eng = ENG_EQP;
          end else begin
            next_swing = swing - 4'h1;
          end
        end
      end
      ENG_EQP: begin
        if (hit_valid_in) begin
          if (hit_count_in >= eq_target || eq == SETTING_MAX) begin
            next_eqp = eq;
            next_eq = 4'h0;
            next_eng = ENG_EQN;
          end else begin
            next_eq = eq + 4'h1;
          end
        end
      end
      ENG_EQN: begin
        if (hit_valid_in) begin
          if (hit_count_in >= eq_target || eq == SETTING_MAX) begin
            if (lane) begin
              next_stat2 = res;
              next_done = 1'b1;
              next_eng = ENG_IDLE;
            end else begin
              next_stat1 = res;
              next_lane = 1'b1;
              next_eng = ENG_MID;
            end
          end else begin
            next_eq = eq + 4'h1;
          end
        end
      end
      ENG_FAST: begin
        if (channel_valid_in) begin
          next_stat1 = channel_long_in[0] ? long1[3:0] : short1[3:0];
          next_stat2 = channel_long_in[1] ? long2[3:0] : short2[3:0];
          next_done = 1'b1;
          next_eng = ENG_IDLE;
        end
      end
      default: next_eng = ENG_IDLE;
    endcase
    if (!adapt_en) next_eng = ENG_IDLE;
  end

  // ****************************************
  // Equalizer outputs
  // ****************************************
  logic [3:0] c1, c2, h1, h2, next_c1, next_c2, next_h1, next_h2, probe_eq, fix1, fix2;
  logic searching;

  assign searching = (eng == ENG_MID) || (eng == ENG_VOD) || (eng == ENG_EQP) || (eng == ENG_EQN);
  assign probe_eq = (eng == ENG_EQP || eng == ENG_EQN) ? eq : mid_eq;
  assign fix1 = i2c_mode ? short1[3:0] : pair_idx(strap[4:3], strap[2:1]);
  assign fix2 = i2c_mode ? short2[3:0] : pair_idx(strap[4:3], strap[2:1]);

  always_comb begin
    next_c1 = (adapt_en && done) ? stat1 : fix1;
    next_c2 = (adapt_en && done) ? stat2 : fix2;
    if (searching && !lane) next_c1 = probe_eq;
    if (searching && lane) next_c2 = probe_eq;
    next_h1 = i2c_mode ? host[3:0] : pair_idx(strap[8:7], strap[6:5]);
    next_h2 = i2c_mode ? host[HOST_L2_LSB+3:HOST_L2_LSB] : pair_idx(strap[8:7], strap[6:5]);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eng <= ENG_IDLE;
      lane <= 1'b0;
      done <= 1'b0;
      swing <= 4'h0;
      eq <= 4'h0;
      eqp <= 4'h0;
      mid_hits <= '0;
      stat1 <= 4'h0;
      stat2 <= 4'h0;
      c1 <= 4'h0;
      c2 <= 4'h0;
      h1 <= 4'h0;
      h2 <= 4'h0;
    end else begin
      eng <= next_eng;
      lane <= next_lane;
      done <= next_done;
      swing <= next_swing;
      eq <= next_eq;
      eqp <= next_eqp;
      mid_hits <= next_mid_hits;
      stat1 <= next_stat1;
      stat2 <= next_stat2;
      c1 <= next_c1;
      c2 <= next_c2;
      h1 <= next_h1;
      h2 <= next_h2;
    end
  end

  assign probe_req_out = searching;
  assign probe_lane_out = lane;
  assign probe_neg_out = (eng == ENG_EQN);
  assign probe_swing_out = swing;
  assign adapt_busy_out = (eng != ENG_IDLE);
  assign conn_lane1_eq_out = c1;
  assign conn_lane2_eq_out = c2;
  assign host_lane1_eq_out = h1;
  assign host_lane2_eq_out = h2;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_addr_hit;
    ist == I_ADDR && scl_fall && !i2c_start && !i2c_stop && bitcnt == BIT_ACK
      && rx[7:1] == dev_addr && i2c_mode;
  endsequence

  a_eq_pick: assert property (eng == ENG_EQP && hit_valid_in && adapt_en
    && hit_count_in >= eq_target |=> eng == ENG_EQN && eqp == $past(eq))
    else $error("eq pick wrong");
  a_swing_pick: assert property (eng == ENG_VOD && hit_valid_in && adapt_en
    && hit_count_in >= sw_target |=> eng == ENG_EQP && swing == $past(swing))
    else $error("swing pick wrong");
  a_thr_default: assert property (mode != MODE_TUNED
    |-> sw_target == scale_hits(mid_hits, 8'h06)) else $error("threshold used");
  a_full_start: assert property (eng == ENG_IDLE && adapt_start_in && adapt_en
    && mode != MODE_FAST |=> eng == ENG_MID ##1 probe_req_out) else $error("full start");
  a_fast_i2c: assert property (eng == ENG_FAST |-> i2c_mode && $past(mode) == MODE_FAST)
    else $error("fast without i2c");
  a_fast_preset: assert property (eng == ENG_FAST && channel_valid_in && adapt_en
    |=> stat1 == ($past(channel_long_in[0]) ? $past(long1[3:0]) : $past(short1[3:0]))
    ##1 conn_lane1_eq_out == stat1 || !adapt_en) else $error("preset wrong");
  a_mid_hold: assert property (eng == ENG_MID && !lane && mode[1]
    |=> conn_lane1_eq_out == $past(midc[3:0])) else $error("mid eq wrong");
  a_addr_ack: assert property (s_addr_hit |=> !sda_oe_n_out ##1 !sda_oe_n_out)
    else $error("no address ack");
endmodule

//--- src/aec_pkg.sv
package aec_pkg;
  // ****************************************
  // Widths and register offsets
  // ****************************************
  localparam int EQ_W = 4;
  localparam logic [7:0] REG_LANE1_ADAPTED = 8'h3B;
  localparam logic [7:0] REG_LANE2_ADAPTED = 8'h3C;
  localparam logic [7:0] REG_MIDCAPTURE = 8'h51;
  localparam logic [7:0] REG_HIT_THRESHOLDS = 8'h52;
  localparam logic [7:0] REG_ADAPT_CTRL = 8'h40;
  localparam logic [7:0] REG_LANE1_SHORT = 8'h41;
  localparam logic [7:0] REG_LANE2_SHORT = 8'h42;
  localparam logic [7:0] REG_LANE1_LONG = 8'h43;
  localparam logic [7:0] REG_LANE2_LONG = 8'h44;
  localparam logic [7:0] REG_HOST_EQ = 8'h45;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] HIT_THRESHOLDS_RST = 8'h86;
  localparam logic [7:0] MIDCAPTURE_RST = 8'h07;
  localparam logic [7:0] ADAPT_CTRL_RST = 8'h06;
  localparam logic [7:0] CONN_EQ_RST = 8'h00;
  localparam logic [7:0] HOST_EQ_RST = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int EQ_THR_LSB = 5;
  localparam int SWING_THR_MSB = 3;
  localparam int MERGE_BIT = 4;
  localparam int ENABLE_BIT = 2;
  localparam int HOST_L2_LSB = 4;
  // ****************************************
  // Constants
  // ****************************************
  localparam logic [6:0] ADDR_BASE = 7'h0E;
  localparam logic [7:0] HIT_SCALE = 8'h80;
  localparam int HIT_SHIFT = 7;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [3:0] SETTING_MAX = 4'hF;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  typedef enum logic [1:0] {
    MODE_FAST = 2'b00, MODE_FULL = 2'b01, MODE_TUNED = 2'b10, MODE_FIXMID = 2'b11
  } aec_mode_t;
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000, ENG_MID = 3'b001, ENG_VOD = 3'b010,
    ENG_EQP = 3'b011, ENG_EQN = 3'b100, ENG_FAST = 3'b101
  } aec_eng_t;
  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_ADDR = 3'b001, I_PTR = 3'b010, I_WDATA = 3'b011, I_RDATA = 3'b100
  } aec_i2c_t;
endpackage

//--- tb/aec_i2c_model.sv
`timescale 1ns/1ps
// ****************************************
// I2C controller on an open-drain bus
// ****************************************
module aec_i2c_model (
  input wire logic clk_in,
  input wire logic sda_dev_in,
  input wire logic sda_oe_n_in,
  output logic scl_out,
  output wire logic sda_out
);
  logic drv = 1'b1;
  // Pull-up: a released line reads high
  assign sda_out = drv & (sda_oe_n_in | sda_dev_in);
  initial scl_out = 1'b1;
  task automatic half();
    repeat (8) @(negedge clk_in);
  endtask
  task automatic clk_bit(input logic b, output logic r);
    drv = b;
    half();
    scl_out = 1'b1;
    half();
    r = sda_out;
    scl_out = 1'b0;
  endtask
  task automatic start();
    drv = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    drv = 1'b0;
    half();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    drv = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    drv = 1'b1;
    half();
  endtask
  task automatic byte_out(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, r);
    ok = ok & ~r;
  endtask
  // Configuration path of the device
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    ok = 1'b1;
    start();
    byte_out({a, 1'b0}, ok);
    byte_out(p, ok);
    byte_out(d, ok);
    stop();
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                          output logic ok);
    logic r;
    ok = 1'b1;
    start();
    byte_out({a, 1'b0}, ok);
    byte_out(p, ok);
    start();
    byte_out({a, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(1'b1, r);
    stop();
  endtask
endmodule

//--- tb/adaptive_eq_control_bench.sv
`timescale 1ns/1ps
module adaptive_eq_control_bench;
  import aec_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ms = 1'b1;
  logic dis_n = 1'b1;
  logic adapt_start = 1'b0;
  logic hit_valid = 1'b0;
  logic ch_valid = 1'b0;
  logic scl;
  logic [1:0] a_hi = 2'h1;
  logic [1:0] a_lo = 2'h1;
  logic [1:0] ch_long = 2'h0;
  logic [3:0] cs = 4'h8;
  logic [15:0] hit_count = 16'h0000;
  logic [15:0] lfsr = 16'h755F;
  wire logic sda, sda_dev, sda_oe_n, req, lane, neg, busy;
  wire logic [3:0] swing, c1, c2, h1, h2;
  int error_cnt = 0;
  int check_count = 0;
  always #2.5 clk_in = ~clk_in;
  aec_control u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .config_mode_strap_in(ms),
    .host_eq_addr_strap_hi_in(a_hi), .host_eq_addr_strap_lo_in(a_lo), .conn_eq_straps_in(cs),
    .adaptation_disable_strap_n_in(dis_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_dev),
    .sda_oe_n_out(sda_oe_n), .adapt_start_in(adapt_start), .hit_valid_in(hit_valid),
    .hit_count_in(hit_count), .channel_valid_in(ch_valid), .channel_long_in(ch_long),
    .probe_req_out(req), .probe_lane_out(lane), .probe_neg_out(neg), .probe_swing_out(swing),
    .adapt_busy_out(busy), .conn_lane1_eq_out(c1), .conn_lane2_eq_out(c2),
    .host_lane1_eq_out(h1), .host_lane2_eq_out(h2));
  aec_i2c_model u_i2c (.clk_in(clk_in), .sda_dev_in(sda_dev), .sda_oe_n_in(sda_oe_n),
    .scl_out(scl), .sda_out(sda));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic int rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return int'(lfsr);
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic wait_on(input logic want_req);
    int n;
    n = 0;
    @(negedge clk_in);
    while (want_req ? (req !== 1'b1) : (busy !== 1'b0)) begin
      n++;
      if (n > 400) begin
        check(16'h0BAD, 16'h0000);
        finish_test();
      end
      @(negedge clk_in);
    end
  endtask
  task automatic pulse(input int h);
    hit_count = h[15:0];
    hit_valid = 1'b1;
    @(negedge clk_in);
    hit_valid = 1'b0;
  endtask
  task automatic start_run();
    adapt_start = 1'b1;
    @(negedge clk_in);
    adapt_start = 1'b0;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    u_i2c.write_reg(7'h12, p, d, ok);
    check(ok, 1);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] p, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    u_i2c.read_reg(a, p, d, ok);
    check(ok, 1);
    check(d, exp);
  endtask
  task automatic do_reset(input logic m, input logic [1:0] hi, input logic [1:0] lo);
    ms = m;
    a_hi = hi;
    a_lo = lo;
    rst_n_in = 1'b0;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (6) @(negedge clk_in);
  endtask
  // Reference model of one full adaptation run
  task automatic run_full(input logic [1:0] md, input logic [7:0] thr, input logic [7:0] aux,
                          input bit rd);
    int et, vt, cap, mid, h, sw, eq;
    int r[2];
    int res[2];
    et = (md == 2'b10) ? int'(thr[7:5]) : 4;
    vt = (md == 2'b10) ? int'(thr[3:0]) : 6;
    cap = md[1] ? int'(aux[3:0]) : 7;
    start_run();
    for (int ln = 0; ln < 2; ln++) begin
      wait_on(1'b1);
      check(lane, ln);
      check(ln ? c2 : c1, cap);
      mid = 512 + (rnd() & 255);
      pulse(mid);
      for (sw = 15; sw >= 0; sw--) begin
        wait_on(1'b1);
        check(swing, sw);
        h = rnd() % (mid / 8);
        pulse(h);
        if (h >= mid * vt / 128) break;
      end
      for (int p = 0; p < 2; p++) begin
        for (eq = 0; eq < 16; eq++) begin
          wait_on(1'b1);
          check(neg, p);
          h = mid - (rnd() & 63);
          pulse(h);
          if (h >= mid * (128 - et) / 128) break;
        end
        r[p] = (eq > 15) ? 15 : eq;
      end
      if (md == 2'b10 && aux[MERGE_BIT]) res[ln] = (r[0] < r[1]) ? r[0] : r[1];
      else res[ln] = (r[0] > r[1]) ? r[0] : r[1];
    end
    wait_on(1'b0);
    check(c1, res[0]);
    check(c2, res[1]);
    if (rd) rd_chk(7'h12, REG_LANE2_ADAPTED, res[1]);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int pre[4];
    logic ok;
    logic [7:0] d;
    logic [7:0] m;
    do_reset(1'b1, 2'h1, 2'h1);
    rd_chk(7'h12, REG_HIT_THRESHOLDS, 8'h86);
    rd_chk(7'h12, REG_MIDCAPTURE, 8'h07);
    rd_chk(7'h12, REG_ADAPT_CTRL, 8'h06);
    u_i2c.read_reg(7'h13, REG_ADAPT_CTRL, d, ok);
    check(ok, 0);
    wr(REG_HIT_THRESHOLDS, 8'hFF);
    rd_chk(7'h12, REG_HIT_THRESHOLDS, 8'hEF);
    for (int i = 0; i < 4; i++) begin
      pre[i] = rnd() & 15;
      wr(REG_LANE1_SHORT + 8'(i), 8'(pre[i]));
    end
    d = 8'(rnd());
    wr(REG_HOST_EQ, d);
    check(h1, d[3:0]);
    check(h2, d[7:4]);
    wr(REG_ADAPT_CTRL, 8'h02);
    start_run();
    repeat (3) @(negedge clk_in);
    check(busy, 0);
    check(c1, pre[0]);
    check(c2, pre[1]);
    wr(REG_ADAPT_CTRL, 8'h04);
    for (int i = 0; i < 4; i++) begin
      start_run();
      @(negedge clk_in);
      ch_long = 2'(i);
      ch_valid = 1'b1;
      @(negedge clk_in);
      ch_valid = 1'b0;
      wait_on(1'b0);
      check(c1, i[0] ? pre[2] : pre[0]);
      check(c2, i[1] ? pre[3] : pre[1]);
      rd_chk(7'h12, REG_LANE1_ADAPTED, 8'(i[0] ? pre[2] : pre[0]));
    end
    for (int i = 1; i < 4; i++) begin
      d = 8'(rnd());
      wr(REG_HIT_THRESHOLDS, d);
      m = 8'(rnd()) & 8'h1F;
      wr(REG_MIDCAPTURE, m);
      wr(REG_ADAPT_CTRL, 8'h04 | 8'(i));
      rd_chk(7'h12, REG_HIT_THRESHOLDS, d & 8'hEF);
      rd_chk(7'h12, REG_MIDCAPTURE, m);
      run_full(2'(i), d, m, 1'b1);
    end
    do_reset(1'b1, 2'h2, 2'h0);
    rd_chk(7'h14, REG_HIT_THRESHOLDS, 8'h86);
    dis_n = 1'b0;
    do_reset(1'b0, 2'h0, 2'h2);
    u_i2c.read_reg(7'h10, REG_ADAPT_CTRL, d, ok);
    check(ok, 0);
    start_run();
    repeat (3) @(negedge clk_in);
    check(busy, 0);
    check(c1, 6);
    check(h1, 2);
    check(h2, 2);
    dis_n = 1'b1;
    do_reset(1'b0, 2'h0, 2'h2);
    run_full(2'b01, 8'h86, 8'h07, 1'b0);
    finish_test();
  end
endmodule
